/* File: rtl/hlt_pkg.sv */
// Purpose: constants, register map and carrier types of the 8-bit hardware-limit timer
// Assumes: one clock (pclk, 25 MHz), apb register access, byte address = 4 * register index
// Notes: register indices are the printed offsets; reserved source codes select nothing
// Functional notes
// - edge monostable modes wait for the chosen reset-input edge, count, then stop at match
// - monostable: pwm drive starts on the starting edge, never on period match
// - monostable: further reset-input edges while counting leave the pwm drive alone
// - level one-shot modes hold the count reset at reset level; start when run and inactive
// - level one-shot: match resets count and clears run; restart needs both conditions again
// - level one-shot: pwm drive starts on whichever event starts the timer
// - with prescaler sync set, the timer halts in sleep; count and period are kept
// - with prescaler sync clear, the timer runs in sleep unless clocked from pclk; a selected internal oscillator stays on
// - count equal to period: next timer clock clears count, in every mode
// - clearing run resets all internal counters and state; some modes clear run themselves
// - 3-bit prescale code divides input clock by two to the power of the code
// - 4-bit postscale code divides period matches by code plus one
// - prescaler sync aligns prescaler output to the instruction clock, pclk divided by four
// - edge select bit: 1 counts falling edges, 0 rising; not changed while running
// - run-bit sync: run passes two input clocks before the timer starts; clearing run stops it at once
// - by default the timer runs while run is 1; stopping keeps the count
// - the mode is the 5-bit field in the low bits of the limit mode register
// - 5-bit clock source code selects pin, instruction clock, system clock, oscillators, logic
// - 5-bit reset source code routes pin, compare, comparator, logic or pwm signal
// - while run is 0 the reset input is ignored in every mode
package hlt_pkg;
    localparam int CLK_FREQ_HZ = 25000000;
    localparam logic [9:0] IDX_COUNT = 10'h38c;
    localparam logic [9:0] IDX_PERIOD = 10'h38d;
    localparam logic [9:0] IDX_RUN_CTRL = 10'h38e;
    localparam logic [9:0] IDX_LIMIT = 10'h38f;
    localparam logic [9:0] IDX_CLK_SEL = 10'h390;
    localparam logic [9:0] IDX_RST_SEL = 10'h391;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic [7:0] RST_RUN_CTRL = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [4:0] RST_CLK_SEL = 5'h00;
    localparam logic [4:0] RST_RST_SEL = 5'h00;
    localparam logic [4:0] MODE_MONO_RISE = 5'h11;
    localparam logic [4:0] MODE_MONO_FALL = 5'h12;
    localparam logic [4:0] MODE_MONO_BOTH = 5'h13;
    localparam logic [4:0] MODE_LVL_LOW = 5'h16;
    localparam logic [4:0] MODE_LVL_HIGH = 5'h17;
    localparam logic [4:0] CS_PIN = 5'h00;
    localparam logic [4:0] CS_INSTR = 5'h01;
    localparam logic [4:0] CS_SYS = 5'h02;
    localparam logic [4:0] CS_FAST = 5'h03;
    localparam logic [4:0] CS_SLOW = 5'h04;
    localparam logic [4:0] CS_MID500 = 5'h05;
    localparam logic [4:0] CS_MID32 = 5'h06;
    localparam logic [4:0] CS_EXT = 5'h08;
    localparam logic [4:0] CS_CLC_FIRST = 5'h0c;
    localparam logic [4:0] CS_CLB_FIRST = 5'h10;
    localparam logic [4:0] RS_PIN = 5'h00;
    localparam logic [4:0] RS_CCP_FIRST = 5'h04;
    localparam logic [4:0] RS_CMP_FIRST = 5'h0e;
    localparam logic [4:0] RS_CLC_FIRST = 5'h11;
    localparam logic [4:0] RS_CLB_FIRST = 5'h15;
    localparam logic [4:0] RS_PWM_FIRST = 5'h1d;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam int RUN_SYNC_STAGES = 2;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic on;
        logic [2:0] prescale_code;
        logic [3:0] postscale_code;
    } hlt_run_ctrl_type;

    typedef struct packed {
        logic prescaler_sync_en;
        logic clock_edge_sel;
        logic run_bit_sync_en;
        logic [4:0] mode;
    } hlt_limit_ctrl_type;

    typedef struct packed {
        logic remapped_input_pin;
        logic external_osc;
        logic fast_internal_osc;
        logic slow_internal_osc;
        logic mid_internal_osc_500k;
        logic mid_internal_osc_32k;
        logic [3:0] config_logic_out;
        logic [3:0] logic_cell_output;
    } hlt_clk_src_type;

    typedef struct packed {
        logic remapped_input_pin;
        logic [1:0] compare_unit_out;
        logic [1:0] comparator_out;
        logic [3:0] config_logic_out;
        logic [7:0] logic_cell_output;
        logic [1:0] pwm_unit_out;
    } hlt_rst_src_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_HELD,
        ST_COUNT,
        ST_DONE
    } hlt_state_type;
endpackage : hlt_pkg

/* File: rtl/hlt_timer.sv */
// Purpose: 8-bit period timer with hardware-limit control, apb register slave
// Assumes: pclk is the system oscillator; async source inputs are synchronised here
// Notes: pready is always high; unmapped addresses answer with pslverr
`timescale 1ns/10ps
`default_nettype none
module hlt_timer
    import hlt_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int COUNT_WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire hlt_clk_src_type clk_src,
    input wire hlt_rst_src_type rst_src,
    input wire logic sleep_mode,
    output logic [7:0] count_value,
    output logic period_match,
    output logic postscaled_match,
    output logic pwm_drive_start,
    output logic timer_running,
    output logic osc_keep_alive
);
    if (ADDR_WIDTH < 12 || COUNT_WIDTH != 8) begin : g_bad_param
        $error("hlt_timer: address must reach 12 bits and the count is 8 bits");
    end

    function automatic logic is_mono(input logic [4:0] m);
        return (m == MODE_MONO_RISE) || (m == MODE_MONO_FALL) || (m == MODE_MONO_BOTH);
    endfunction : is_mono

    function automatic logic is_level(input logic [4:0] m);
        return (m == MODE_LVL_LOW) || (m == MODE_LVL_HIGH);
    endfunction : is_level

    function automatic logic [6:0] prescale_last(input logic [2:0] code);
        // shifting 1 by 7 wraps to zero, so the subtraction still gives 127
        return 7'((7'h01 << code) - 7'h01);
    endfunction : prescale_last

    function automatic logic [1:0] pick_clk(input logic [4:0] sel, input hlt_clk_src_type s);
        // returns {valid, level}; reserved codes are invalid and read low
        logic [1:0] r;
        r = 2'h0;
        case (sel)
            CS_PIN: r = {1'b1, s.remapped_input_pin};
            CS_FAST: r = {1'b1, s.fast_internal_osc};
            CS_SLOW: r = {1'b1, s.slow_internal_osc};
            CS_MID500: r = {1'b1, s.mid_internal_osc_500k};
            CS_MID32: r = {1'b1, s.mid_internal_osc_32k};
            CS_EXT: r = {1'b1, s.external_osc};
            default: begin
                if (sel >= CS_CLC_FIRST && sel < CS_CLB_FIRST) begin
                    r = {1'b1, s.config_logic_out[2'(sel - CS_CLC_FIRST)]};
                end else if (sel >= CS_CLB_FIRST && sel < 5'(CS_CLB_FIRST + 5'h04)) begin
                    r = {1'b1, s.logic_cell_output[2'(sel - CS_CLB_FIRST)]};
                end
            end
        endcase
        return r;
    endfunction : pick_clk

    function automatic logic [1:0] pick_rst(input logic [4:0] sel, input hlt_rst_src_type s);
        logic [1:0] r;
        r = 2'h0;
        if (sel == RS_PIN) begin
            r = {1'b1, s.remapped_input_pin};
        end else if (sel >= RS_CCP_FIRST && sel < 5'(RS_CCP_FIRST + 5'h02)) begin
            r = {1'b1, s.compare_unit_out[1'(sel - RS_CCP_FIRST)]};
        end else if (sel >= RS_CMP_FIRST && sel < 5'(RS_CMP_FIRST + 5'h02)) begin
            r = {1'b1, s.comparator_out[1'(sel - RS_CMP_FIRST)]};
        end else if (sel >= RS_CLC_FIRST && sel < RS_CLB_FIRST) begin
            r = {1'b1, s.config_logic_out[2'(sel - RS_CLC_FIRST)]};
        end else if (sel >= RS_CLB_FIRST && sel < RS_PWM_FIRST) begin
            r = {1'b1, s.logic_cell_output[3'(sel - RS_CLB_FIRST)]};
        end else if (sel >= RS_PWM_FIRST && sel < 5'(RS_PWM_FIRST + 5'h02)) begin
            r = {1'b1, s.pwm_unit_out[1'(sel - RS_PWM_FIRST)]};
        end
        return r;
    endfunction : pick_rst

    // register state
    logic [7:0] count, next_count;
    logic [7:0] period, next_period;
    hlt_run_ctrl_type run, next_run;
    hlt_limit_ctrl_type lim, next_lim;
    logic [4:0] clk_sel, next_clk_sel;
    logic [4:0] rst_sel, next_rst_sel;
    hlt_state_type state, next_state;
    logic [6:0] pre_cnt, next_pre_cnt;
    logic [3:0] post_cnt, next_post_cnt;
    logic prescaler_sync_en_pend, next_prescaler_sync_en_pend;
    logic [RUN_SYNC_STAGES-1:0] run_pipe, next_run_pipe;
    logic match_q, next_match_q;
    logic post_q, next_post_q;
    logic pwm_q, next_pwm_q;
    logic keep_q, next_keep_q;
    logic [31:0] rdata_q, next_rdata_q;

    // synchroniser state
    logic [SYNC_STAGES-1:0] clk_sync, next_clk_sync;
    logic [SYNC_STAGES-1:0] rst_sync, next_rst_sync;
    logic clk_level, next_clk_level;
    logic clk_prev, next_clk_prev;
    logic rst_level, next_rst_level;
    logic rst_prev, next_rst_prev;
    logic [1:0] instr_div, next_instr_div;

    logic [1:0] clk_pick;
    logic [1:0] rst_pick;
    logic instr_phase;
    logic clk_edge;
    logic rst_rise;
    logic rst_fall;
    logic run_eff;
    logic pre_en;
    logic pre_tick;
    logic tick;
    logic level_reset;
    logic mono_hit;
    logic [9:0] reg_idx;
    logic addr_hit;
    logic wr_en;
    logic rd_setup;
    logic [7:0] rd_byte;

    assign clk_pick = pick_clk(clk_sel, clk_src);
    assign rst_pick = pick_rst(rst_sel, rst_src);
    assign instr_phase = (instr_div == INSTR_DIV_LAST);

    always_comb begin
        next_instr_div = 2'(instr_div + 2'h1);
        next_clk_sync = {clk_sync[SYNC_STAGES-2:0], clk_pick[0]};
        next_rst_sync = {rst_sync[SYNC_STAGES-2:0], rst_pick[0]};
        next_clk_level = clk_level;
        next_rst_level = rst_level;
        // a level counts only once the second and third stages agree
        if (clk_sync[1] == clk_sync[2]) begin
            next_clk_level = clk_sync[2];
        end
        if (rst_sync[1] == rst_sync[2]) begin
            next_rst_level = rst_sync[2];
        end
        next_clk_prev = clk_level;
        next_rst_prev = rst_level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_div <= 2'h0;
            clk_sync <= '0;
            rst_sync <= '0;
            clk_level <= 1'b0;
            clk_prev <= 1'b0;
            rst_level <= 1'b0;
            rst_prev <= 1'b0;
        end else begin
            instr_div <= next_instr_div;
            clk_sync <= next_clk_sync;
            rst_sync <= next_rst_sync;
            clk_level <= next_clk_level;
            clk_prev <= next_clk_prev;
            rst_level <= next_rst_level;
            rst_prev <= next_rst_prev;
        end
    end

    // the pclk-derived sources stop in sleep because the core clock tree is gated there
    always_comb begin
        clk_edge = 1'b0;
        if (clk_sel == CS_SYS) begin
            clk_edge = !sleep_mode;
        end else if (clk_sel == CS_INSTR) begin
            clk_edge = instr_phase && !sleep_mode;
        end else if (clk_pick[1]) begin
            clk_edge = lim.clock_edge_sel ? (clk_prev && !clk_level)
                                          : (!clk_prev && clk_level);
        end
    end

    assign rst_rise = rst_pick[1] && !rst_prev && rst_level;
    assign rst_fall = rst_pick[1] && rst_prev && !rst_level;
    assign mono_hit = ((lim.mode == MODE_MONO_RISE) && rst_rise)
                   || ((lim.mode == MODE_MONO_FALL) && rst_fall)
                   || ((lim.mode == MODE_MONO_BOTH) && (rst_rise || rst_fall));
    assign level_reset = rst_pick[1] && is_level(lim.mode)
                      && (rst_level == (lim.mode == MODE_LVL_HIGH));

    // run reaches the counter two input clocks late when run-bit sync is on
    assign run_eff = lim.run_bit_sync_en ? (run_pipe[RUN_SYNC_STAGES-1] && run.on)
                                         : run.on;
    assign pre_en = run_eff && clk_edge && !(lim.prescaler_sync_en && sleep_mode);
    assign pre_tick = pre_en && (pre_cnt == prescale_last(run.prescale_code));
    // prescaler output waits for the instruction clock phase so count reads are stable
    assign tick = lim.prescaler_sync_en
                ? ((prescaler_sync_en_pend || pre_tick) && instr_phase && !sleep_mode && run_eff)
                : pre_tick;

    assign reg_idx = paddr[11:2];
    assign addr_hit = (paddr[1:0] == 2'h0) && ((paddr >> 12) == '0)
                   && (reg_idx >= IDX_COUNT) && (reg_idx <= IDX_RST_SEL);
    assign wr_en = psel && penable && pwrite && addr_hit;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        rd_byte = 8'h00;
        case (reg_idx)
            IDX_COUNT: rd_byte = count;
            IDX_PERIOD: rd_byte = period;
            IDX_RUN_CTRL: rd_byte = run;
            IDX_LIMIT: rd_byte = lim;
            IDX_CLK_SEL: rd_byte = {3'h0, clk_sel};
            IDX_RST_SEL: rd_byte = {3'h0, rst_sel};
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_count = count;
        next_period = period;
        next_run = run;
        next_lim = lim;
        next_clk_sel = clk_sel;
        next_rst_sel = rst_sel;
        next_state = state;
        next_pre_cnt = pre_cnt;
        next_post_cnt = post_cnt;
        next_prescaler_sync_en_pend = prescaler_sync_en_pend;
        next_run_pipe = run_pipe;
        next_match_q = 1'b0;
        next_post_q = 1'b0;
        next_pwm_q = 1'b0;
        next_keep_q = sleep_mode && !lim.prescaler_sync_en && run.on
                   && (clk_sel inside {CS_FAST, CS_SLOW, CS_MID500, CS_MID32});
        next_rdata_q = rdata_q;

        if (!run.on) begin
            next_run_pipe = '0;
        end else if (clk_edge) begin
            next_run_pipe = {run_pipe[RUN_SYNC_STAGES-2:0], 1'b1};
        end

        if (!run_eff) begin
            // count is kept; everything else returns to its start; reset input unseen
            next_state = ST_IDLE;
            next_pre_cnt = 7'h00;
            next_post_cnt = 4'h0;
            next_prescaler_sync_en_pend = 1'b0;
        end else begin
            if (pre_en) begin
                next_pre_cnt = pre_tick ? 7'h00 : 7'(pre_cnt + 7'h01);
            end
            if (lim.prescaler_sync_en) begin
                next_prescaler_sync_en_pend = (prescaler_sync_en_pend || pre_tick) && !tick;
            end
            case (state)
                ST_IDLE: begin
                    if (is_mono(lim.mode)) begin
                        next_state = ST_ARMED;
                    end else if (is_level(lim.mode)) begin
                        next_state = ST_HELD;
                    end else begin
                        next_state = ST_COUNT;
                    end
                end
                ST_ARMED: begin
                    if (mono_hit) begin
                        next_state = ST_COUNT;
                        next_pwm_q = 1'b1;
                    end
                end
                ST_HELD: begin
                    next_count = 8'h00;
                    if (!level_reset) begin
                        next_state = ST_COUNT;
                        next_pwm_q = 1'b1;
                    end
                end
                ST_COUNT: begin
                    if (level_reset) begin
                        next_state = ST_HELD;
                        next_count = 8'h00;
                    end else if (tick) begin
                        if (count == period) begin
                            next_count = 8'h00;
                            next_match_q = 1'b1;
                            if (post_cnt == run.postscale_code) begin
                                next_post_cnt = 4'h0;
                                next_post_q = 1'b1;
                            end else begin
                                next_post_cnt = 4'(post_cnt + 4'h1);
                            end
                            if (is_mono(lim.mode)) begin
                                next_state = ST_DONE;
                            end else if (is_level(lim.mode)) begin
                                next_run.on = 1'b0;
                                next_state = ST_IDLE;
                            end else begin
                                next_pwm_q = 1'b1;
                            end
                        end else begin
                            next_count = 8'(count + 8'h01);
                        end
                    end
                    // monostable edges during counting are not looked at here
                end
                ST_DONE: begin
                    next_state = ST_DONE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end

        // a software write lands after the hardware update and so wins in the same cycle
        if (wr_en) begin
            case (reg_idx)
                IDX_COUNT: next_count = pwdata[7:0];
                IDX_PERIOD: next_period = pwdata[7:0];
                IDX_RUN_CTRL: next_run = hlt_run_ctrl_type'(pwdata[7:0]);
                IDX_LIMIT: next_lim = hlt_limit_ctrl_type'(pwdata[7:0]);
                IDX_CLK_SEL: next_clk_sel = pwdata[4:0];
                IDX_RST_SEL: next_rst_sel = pwdata[4:0];
                default: next_count = next_count;
            endcase
        end
        if (rd_setup) begin
            next_rdata_q = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= RST_COUNT;
            period <= RST_PERIOD;
            run <= hlt_run_ctrl_type'(RST_RUN_CTRL);
            lim <= hlt_limit_ctrl_type'(RST_LIMIT);
            clk_sel <= RST_CLK_SEL;
            rst_sel <= RST_RST_SEL;
            state <= ST_IDLE;
            pre_cnt <= 7'h00;
            post_cnt <= 4'h0;
            prescaler_sync_en_pend <= 1'b0;
            run_pipe <= '0;
            match_q <= 1'b0;
            post_q <= 1'b0;
            pwm_q <= 1'b0;
            keep_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            count <= next_count;
            period <= next_period;
            run <= next_run;
            lim <= next_lim;
            clk_sel <= next_clk_sel;
            rst_sel <= next_rst_sel;
            state <= next_state;
            pre_cnt <= next_pre_cnt;
            post_cnt <= next_post_cnt;
            prescaler_sync_en_pend <= next_prescaler_sync_en_pend;
            run_pipe <= next_run_pipe;
            match_q <= next_match_q;
            post_q <= next_post_q;
            pwm_q <= next_pwm_q;
            keep_q <= next_keep_q;
            rdata_q <= next_rdata_q;
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign count_value = count;
    assign period_match = match_q;
    assign postscaled_match = post_q;
    assign pwm_drive_start = pwm_q;
    assign timer_running = (state == ST_COUNT);
    assign osc_keep_alive = keep_q;
endmodule : hlt_timer
`default_nettype wire

/* File: tb/hlt_checker.sv */
// Purpose: port-level assertions for hlt_timer
// Assumes: one pclk domain, presetn async active low
// Notes: bound to every hlt_timer instance
`timescale 1ns/10ps
`default_nettype none
module hlt_checker #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_mode,
    input wire logic [7:0] count_value,
    input wire logic period_match,
    input wire logic postscaled_match,
    input wire logic timer_running,
    input wire logic osc_keep_alive
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("stray pslverr");
    a_err_align: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned not refused");
    a_read_upper: assert property (prdata[31:8] == 24'h0) else $error("prdata high bits");
    a_match_clear: assert property (period_match |-> count_value == 8'h00)
        else $error("count not cleared at match");
    a_post_sub: assert property (postscaled_match |-> period_match)
        else $error("postscaled without match");
    a_osc_sleep: assert property (osc_keep_alive |-> $past(sleep_mode))
        else $error("oscillator kept outside sleep");
    // a stopped timer only moves on a software write or a level-mode hold to zero
    a_stop_hold: assert property (!timer_running && !(psel && penable && pwrite)
        |=> $stable(count_value) || count_value == 8'h00) else $error("count moved while stopped");
endmodule : hlt_checker
bind hlt_timer hlt_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .sleep_mode, .count_value, .period_match,
    .postscaled_match, .timer_running, .osc_keep_alive);
`default_nettype wire

/* File: tb/hlt_src_model.sv */
// Purpose: far-side clock and reset sources for hlt_timer
// Assumes: ers is the wanted level of the pin reset source
// Notes: unselected sources carry a moving pattern, so a wrong select shows up
`timescale 1ns/10ps
`default_nettype none
module hlt_src_model
    import hlt_pkg::*;
(
    input wire logic pclk,
    output hlt_clk_src_type clk_src,
    output hlt_rst_src_type rst_src,
    input wire logic ers
);
    logic [17:0] pat = 18'h00001;
    always @(posedge pclk) begin
        pat <= {pat[16:0], pat[17] ^ pat[10]};
    end
    assign clk_src = {pat[0], pat[13:1]};
    assign rst_src = {ers, pat};
endmodule : hlt_src_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for hlt_timer
// Assumes: pready answer awaited, every wait bounded
// Notes: random period and postscale from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    import hlt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0, ers = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h7d16d6e7;
    logic pready, pslverr, period_match, postscaled_match, pwm_drive_start, timer_running;
    logic osc_keep_alive, e;
    logic [7:0] count_value, c;
    hlt_clk_src_type clk_src;
    hlt_rst_src_type rst_src;
    int err_total = 0, n_compared = 0, cyc = 0, pwm_n = 0, t0, n, p, q;
    logic [9:0] ix [6] = '{IDX_COUNT, IDX_PERIOD, IDX_RUN_CTRL, IDX_LIMIT, IDX_CLK_SEL, IDX_RST_SEL};
    logic [7:0] rv [6] = '{RST_COUNT, RST_PERIOD, RST_RUN_CTRL, RST_LIMIT, 8'h00, 8'h00};
    logic [4:0] lm [2] = '{MODE_LVL_HIGH, MODE_LVL_LOW};
    logic [4:0] mm [3] = '{MODE_MONO_RISE, MODE_MONO_FALL, MODE_MONO_BOTH};
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        pwm_n <= pwm_n + int'(pwm_drive_start === 1'b1);
    end
    hlt_src_model ptn (.pclk, .clk_src, .rst_src, .ers);
    hlt_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .clk_src, .rst_src, .sleep_mode, .count_value, .period_match,
        .postscaled_match, .pwm_drive_start, .timer_running, .osc_keep_alive);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic summarize();
        $display("errors %0d, comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic wait_for(ref logic s);
        n = 0;
        do @(posedge pclk); while (s !== 1'b1 && ++n < 20000);
        if (n >= 20000) begin
            err_total++;
            summarize();
        end
    endtask : wait_for
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        wait_for(pready);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ix[i]) begin
            apb(0, ix[i], 8'h00);
            `CHK(r[7:0], rv[i])
        end
        apb(0, 10'h001, 8'h00);
        `CHK(e, 1'b1)
        apb(1, IDX_CLK_SEL, {3'h0, CS_SYS});
        for (int k = 0; k < 8; k++) begin
            p = (k == 0) ? 0 : int'(rnd() % 4);
            q = (k == 7) ? 15 : int'(rnd() % 16);
            apb(1, IDX_PERIOD, 8'(p));
            apb(1, IDX_RUN_CTRL, {1'b1, 3'(k), 4'(q)});
            wait_for(postscaled_match);
            t0 = cyc;
            wait_for(postscaled_match);
            `CHK(cyc - t0, ((p + 1) * (q + 1)) << k)
            apb(1, IDX_RUN_CTRL, 8'h00);
        end
        apb(1, IDX_PERIOD, 8'h05);
        apb(1, IDX_COUNT, 8'h00);
        foreach (lm[i]) begin
            ers <= lm[i][0];
            apb(1, IDX_LIMIT, {3'h0, lm[i]});
            apb(1, IDX_RUN_CTRL, 8'h80);
            repeat (20) @(posedge pclk);
            `CHK({timer_running, count_value}, 9'h000)
            ers <= ~lm[i][0];
            wait_for(pwm_drive_start);
            wait_for(period_match);
            apb(0, IDX_RUN_CTRL, 8'h00);
            `CHK({r[7], timer_running}, 2'b00)
            apb(1, IDX_RUN_CTRL, 8'h80);
            wait_for(pwm_drive_start);
            wait_for(period_match);
        end
        apb(1, IDX_PERIOD, 8'h30);
        foreach (mm[i]) begin
            ers <= (mm[i] == MODE_MONO_FALL);
            apb(1, IDX_LIMIT, {3'h0, mm[i]});
            apb(1, IDX_RUN_CTRL, 8'h80);
            repeat (10) @(posedge pclk);
            `CHK(timer_running, 1'b0)
            t0 = pwm_n;
            // first toggle starts, the two later ones land while counting
            repeat (3) begin
                ers <= ~ers;
                repeat (8) @(posedge pclk);
            end
            `CHK(timer_running, 1'b1)
            wait_for(period_match);
            repeat (10) @(posedge pclk);
            `CHK({timer_running, count_value}, 9'h000)
            `CHK(pwm_n - t0, 1)
            apb(1, IDX_RUN_CTRL, 8'h00);
        end
        // a source that keeps toggling in sleep, so only the sync bit can halt the count
        apb(1, IDX_CLK_SEL, {3'h0, CS_FAST});
        apb(1, IDX_LIMIT, 8'h80);
        apb(1, IDX_RUN_CTRL, 8'h80);
        sleep_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        c = count_value;
        repeat (40) @(posedge pclk);
        `CHK(count_value, c)
        apb(1, IDX_LIMIT, 8'h00);
        repeat (4) @(posedge pclk);
        `CHK(osc_keep_alive, 1'b1)
        c = count_value;
        repeat (40) @(posedge pclk);
        `CHK(count_value != c, 1'b1)
        summarize();
    end
endmodule : tb
`default_nettype wire
